// File: smc_regs.svh
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SMC_SLEEP_CTRL_OFS   12'h000
`define SMC_CPU_CTRL_OFS     12'h004
`define SMC_STATUS_OFS       12'h008

// ----------------------------------------
// field positions
// ----------------------------------------
`define SMC_SE_BIT           0
`define SMC_SM_LSB           1
`define SMC_BROWNOUT_SLEEP_OFF_BIT         6
`define SMC_BROWNOUT_SLEEP_UNLOCK_BIT        5

// ----------------------------------------
// reset values and sleep mode codes
// ----------------------------------------
`define SMC_SLEEP_CTRL_RST   4'h0
`define SMC_MODE_IDLE        3'h0
`define SMC_MODE_ADCNR       3'h1
`define SMC_MODE_PDOWN       3'h2
`define SMC_MODE_PSAVE       3'h3
`define SMC_MODE_STBY        3'h6

// ----------------------------------------
// timing
// ----------------------------------------
`define SMC_CLK_PERIOD_NS    25
`define SMC_BOD_WAKE_NS      60000
`define SMC_BOD_WAKE_CYC     ((`SMC_BOD_WAKE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_HALT_CYC         4
`define SMC_STBY_WAKE_CYC    6
`define SMC_UNLOCK_CYC       4
`define SMC_BROWNOUT_SLEEP_OFF_DELAY_CYC   3
`define SMC_BROWNOUT_SLEEP_OFF_HOLD_CYC    3

`endif

// File: smc_pkg.sv
package smc_pkg;

  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_SLEEP,
    SMC_WAKE
  } smc_state_t;

  // wake sources, all from asynchronous logic or pins
  typedef struct packed {
    logic irq_any;      // any enabled interrupt pending
    logic adc_done;
    logic lcd_irq;
    logic start_irq;
    logic t2_ovf;
    logic t2_cmp;
    logic t2_irq;
    logic spm_ready;
    logic external_irq_zero_level;
    logic pin_change;
  } smc_wake_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic async;
    logic main_osc;
    logic tosc;
  } smc_clk_en_t;

endpackage

// File: smc_sleep_ctrl.sv
`timescale 1ns/1ps
`include "smc_regs.svh"

// Contract
// - sleep happens only with sleep enable set and a sleep instruction
// - mode 000 idle: stop cpu and flash clocks, wake on any interrupt
// - mode 001 noise reduction: also stop io clock, keep adc and async
// - mode 010 power-down: stop all generated clocks
// - mode 011 power-save: as power-down, timer 2 and lcd keep running
// - mode 110 with crystal: standby, oscillator runs, wake in six cycles
// - interrupt wake holds core four cycles plus start-up, then resumes
// - register file and sram keep contents through sleep and wake
// - reset during sleep wakes core to the reset vector
// - requested brown-out off applies after entry, restored at wake
// - wake after brown-out off lasts at least 60 us
// - brown-out sleep-off is bit 6 of cpu control, reset zero
// - brown-out off only in power-down, power-save and standby
// - brown-out sleep-off written only through unlock timed sequence
// - adc enabled at idle or noise reduction entry starts a conversion
// - noise reduction wakes only on listed sources
// - power-down stops oscillator, wakes only on listed sources
// - power-down wake waits clock start-up set by clock source fuses
// - power-save wakes on enabled timer 2 events or lcd interrupt
// - power-save stops timer oscillator when nothing runs asynchronously
// - power-save stops main clock when nothing runs synchronously
// - sleep-off active three cycles after set, clears three later
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned SU_UNIT = 64   // start-up cycles per fuse step
) (
  input  wire logic        i_clk,          // 40 MHz system clock
  input  wire logic        i_rstn,         // async reset, active low
  input  wire logic        i_psel,         // apb select
  input  wire logic        i_penable,      // apb enable
  input  wire logic        i_pwrite,       // apb direction
  input  wire logic [11:0] i_paddr,        // apb byte address
  input  wire logic [31:0] i_pwdata,       // apb write data
  output logic      [31:0] o_prdata,       // apb read data
  output logic             o_pready,       // apb ready
  output logic             o_pslverr,      // apb error, unmapped
  input  wire logic        i_sleep_instr,  // core executes sleep, pulse
  input  wire logic        i_reset_event,  // ext, watchdog or brown-out reset
  input  wire smc_wake_t   i_wake,         // asynchronous wake sources
  input  wire logic        i_t2_irq_ovf_en,// timer 2 overflow irq enable
  input  wire logic        i_t2_irq_cmp_en,// timer 2 compare irq enable
  input  wire logic        i_global_ie,    // global interrupt enable
  input  wire logic        i_xtal_sel,     // crystal clock option chosen
  input  wire logic [3:0]  i_clk_src_fuses,// clock source fuses
  input  wire logic        i_adc_enabled,  // adc enabled
  input  wire logic        i_async_used,   // t2 or lcd on async clock
  input  wire logic        i_sync_used,    // t2 or lcd on sync clock
  output smc_clk_en_t      o_clk_en,       // clock enables, high runs
  output logic             o_core_hold,    // core halted
  output logic             o_adc_start,    // conversion start pulse
  output logic             o_bod_off,      // brown-out detector off
  output logic             o_resume_irq,   // resume to irq, pulse
  output logic             o_resume_reset  // resume at reset vector, pulse
);

  // ----------------------------------------
  // wake source synchroniser
  // ----------------------------------------
  localparam int WW = $bits(smc_wake_t);
  logic [WW-1:0] s1_r, s2_r, s3_r, wk_r, wk_nxt;
  logic          rst_s1_r, rst_s2_r, rst_s3_r, rst_q_r, rst_q_nxt;

  always_comb begin
    // a change counts once stages two and three agree
    wk_nxt    = (s2_r & s3_r) | (wk_r & (s2_r | s3_r));
    rst_q_nxt = (rst_s2_r & rst_s3_r) | (rst_q_r & (rst_s2_r | rst_s3_r));
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_r     <= '0;
      s2_r     <= '0;
      s3_r     <= '0;
      wk_r     <= '0;
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
      rst_s3_r <= 1'b0;
      rst_q_r  <= 1'b0;
    end else begin
      s1_r     <= i_wake;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      wk_r     <= wk_nxt;
      rst_s1_r <= i_reset_event;
      rst_s2_r <= rst_s1_r;
      rst_s3_r <= rst_s2_r;
      rst_q_r  <= rst_q_nxt;
    end
  end

  smc_wake_t wk;
  assign wk = smc_wake_t'(wk_r);

  // ----------------------------------------
  // registers and apb slave
  // ----------------------------------------
  logic       se_r, se_nxt;
  logic [2:0] sm_r, sm_nxt;
  logic       unlock_r, unlock_nxt;
  logic [2:0] unl_cnt_r, unl_cnt_nxt;
  logic [2:0] brownout_sleep_off_cnt_r, brownout_sleep_off_cnt_nxt;
  logic       wr_acc, rd_acc, hit;
  logic       brownout_sleep_off_active;

  assign wr_acc   = i_psel && i_penable && i_pwrite;
  // read data latched in setup so it already stands at the access edge
  assign rd_acc   = i_psel && !i_penable && !i_pwrite;
  assign hit      = (i_paddr == `SMC_SLEEP_CTRL_OFS) || (i_paddr == `SMC_CPU_CTRL_OFS) ||
                    (i_paddr == `SMC_STATUS_OFS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  // active window: counts 3..1 after a 3-cycle arming delay
  assign brownout_sleep_off_active = (brownout_sleep_off_cnt_r != 3'h0) && (brownout_sleep_off_cnt_r <= 3'(`SMC_BROWNOUT_SLEEP_OFF_HOLD_CYC));

  always_comb begin
    se_nxt       = se_r;
    sm_nxt       = sm_r;
    unlock_nxt   = unlock_r;
    unl_cnt_nxt  = unl_cnt_r;
    brownout_sleep_off_cnt_nxt = brownout_sleep_off_cnt_r;
    if (unl_cnt_r != 3'h0) begin
      unl_cnt_nxt = unl_cnt_r - 3'h1;
    end else begin
      unlock_nxt = 1'b0;
    end
    if (brownout_sleep_off_cnt_r != 3'h0) begin
      brownout_sleep_off_cnt_nxt = brownout_sleep_off_cnt_r - 3'h1;
    end
    if (wr_acc && i_paddr == `SMC_SLEEP_CTRL_OFS) begin
      se_nxt = i_pwdata[`SMC_SE_BIT];
      sm_nxt = i_pwdata[`SMC_SM_LSB +: 3];
    end
    if (wr_acc && i_paddr == `SMC_CPU_CTRL_OFS) begin
      if (i_pwdata[`SMC_BROWNOUT_SLEEP_OFF_BIT] && i_pwdata[`SMC_BROWNOUT_SLEEP_UNLOCK_BIT]) begin
        // rewriting the unlock does not extend the window
        if (!unlock_r) begin
          unlock_nxt  = 1'b1;
          unl_cnt_nxt = 3'(`SMC_UNLOCK_CYC);
        end
      end else if (unlock_r && i_pwdata[`SMC_BROWNOUT_SLEEP_OFF_BIT] && !i_pwdata[`SMC_BROWNOUT_SLEEP_UNLOCK_BIT]) begin
        unlock_nxt   = 1'b0;
        unl_cnt_nxt  = 3'h0;
        brownout_sleep_off_cnt_nxt = 3'(`SMC_BROWNOUT_SLEEP_OFF_DELAY_CYC + `SMC_BROWNOUT_SLEEP_OFF_HOLD_CYC);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      se_r       <= 1'b0;
      sm_r       <= 3'h0;
      unlock_r   <= 1'b0;
      unl_cnt_r  <= 3'h0;
      brownout_sleep_off_cnt_r <= 3'h0;
    end else begin
      se_r       <= se_nxt;
      sm_r       <= sm_nxt;
      unlock_r   <= unlock_nxt;
      unl_cnt_r  <= unl_cnt_nxt;
      brownout_sleep_off_cnt_r <= brownout_sleep_off_cnt_nxt;
    end
  end

  // ----------------------------------------
  // sleep sequencer
  // ----------------------------------------
  smc_state_t  st_r, st_nxt;
  logic [2:0]  mode_r, mode_nxt;
  logic        bod_off_r, bod_off_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic        adc_start_nxt, res_irq_nxt, res_rst_nxt;
  logic        adc_start_r, res_irq_r, res_rst_r;
  logic        mode_ok, wake_ok, deep;
  logic [11:0] wake_len;

  // reserved codes and standby without crystal are refused
  assign mode_ok = (sm_r == `SMC_MODE_IDLE) || (sm_r == `SMC_MODE_ADCNR) ||
                   (sm_r == `SMC_MODE_PDOWN) || (sm_r == `SMC_MODE_PSAVE) ||
                   ((sm_r == `SMC_MODE_STBY) && i_xtal_sel);
  assign deep    = (mode_r == `SMC_MODE_PDOWN) || (mode_r == `SMC_MODE_PSAVE) ||
                   (mode_r == `SMC_MODE_STBY);

  always_comb begin
    case (mode_r)
      `SMC_MODE_IDLE:  wake_ok = wk.irq_any;
      `SMC_MODE_ADCNR: wake_ok = wk.adc_done | wk.lcd_irq | wk.start_irq |
                                 wk.t2_irq | wk.spm_ready | wk.external_irq_zero_level | wk.pin_change;
      `SMC_MODE_PSAVE: wake_ok = wk.start_irq | wk.external_irq_zero_level | wk.pin_change | wk.lcd_irq |
                                 (i_global_ie & ((wk.t2_ovf & i_t2_irq_ovf_en) |
                                                 (wk.t2_cmp & i_t2_irq_cmp_en)));
      default:         wake_ok = wk.start_irq | wk.external_irq_zero_level | wk.pin_change;
    endcase
  end

  always_comb begin
    case (mode_r)
      `SMC_MODE_PDOWN,
      `SMC_MODE_PSAVE: wake_len = 12'(({8'h00, i_clk_src_fuses} + 12'h001) * SU_UNIT) +
                                  12'(`SMC_HALT_CYC);
      `SMC_MODE_STBY:  wake_len = 12'(`SMC_STBY_WAKE_CYC);
      default:         wake_len = 12'(`SMC_HALT_CYC);
    endcase
    // brown-out needs time to settle before code runs
    if (bod_off_r && wake_len < 12'(`SMC_BOD_WAKE_CYC)) begin
      wake_len = 12'(`SMC_BOD_WAKE_CYC);
    end
  end

  always_comb begin
    st_nxt        = st_r;
    mode_nxt      = mode_r;
    bod_off_nxt   = bod_off_r;
    cnt_nxt       = cnt_r;
    adc_start_nxt = 1'b0;
    res_irq_nxt   = 1'b0;
    res_rst_nxt   = 1'b0;
    case (st_r)
      SMC_RUN: begin
        if (i_sleep_instr && se_r && mode_ok) begin
          st_nxt        = SMC_SLEEP;
          mode_nxt      = sm_r;
          adc_start_nxt = i_adc_enabled && (sm_r == `SMC_MODE_IDLE || sm_r == `SMC_MODE_ADCNR);
          bod_off_nxt   = brownout_sleep_off_active && (sm_r == `SMC_MODE_PDOWN || sm_r == `SMC_MODE_PSAVE ||
                                          sm_r == `SMC_MODE_STBY);
        end
      end
      SMC_SLEEP: begin
        if (rst_q_r) begin
          st_nxt      = SMC_RUN;
          bod_off_nxt = 1'b0;
          res_rst_nxt = 1'b1;
        end else if (wake_ok) begin
          st_nxt      = SMC_WAKE;
          bod_off_nxt = 1'b0;
          cnt_nxt     = wake_len - 12'h001;
        end
      end
      SMC_WAKE: begin
        bod_off_nxt = 1'b0;
        if (rst_q_r) begin
          st_nxt      = SMC_RUN;
          res_rst_nxt = 1'b1;
        end else if (cnt_r == 12'h000) begin
          st_nxt      = SMC_RUN;
          res_irq_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: st_nxt = SMC_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r        <= SMC_RUN;
      mode_r      <= 3'h0;
      bod_off_r   <= 1'b0;
      cnt_r       <= 12'h000;
      adc_start_r <= 1'b0;
      res_irq_r   <= 1'b0;
      res_rst_r   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      mode_r      <= mode_nxt;
      bod_off_r   <= bod_off_nxt;
      cnt_r       <= cnt_nxt;
      adc_start_r <= adc_start_nxt;
      res_irq_r   <= res_irq_nxt;
      res_rst_r   <= res_rst_nxt;
    end
  end

  // ----------------------------------------
  // clock gating and outputs
  // ----------------------------------------
  logic sleeping;
  assign sleeping = (st_r == SMC_SLEEP);

  // core is clock-stopped, never powered off, so its state survives
  always_comb begin
    o_clk_en.cpu      = (st_r == SMC_RUN);
    o_clk_en.flash    = (st_r == SMC_RUN);
    o_clk_en.io       = !sleeping || (mode_r == `SMC_MODE_IDLE);
    o_clk_en.adc      = !sleeping || (mode_r == `SMC_MODE_IDLE) || (mode_r == `SMC_MODE_ADCNR);
    o_clk_en.async    = !sleeping || !deep || (mode_r == `SMC_MODE_PSAVE);
    o_clk_en.main_osc = !sleeping || !deep || (mode_r == `SMC_MODE_STBY) ||
                        ((mode_r == `SMC_MODE_PSAVE) && i_sync_used);
    o_clk_en.tosc     = !sleeping || !deep ||
                        ((mode_r == `SMC_MODE_PSAVE) && i_async_used);
  end

  assign o_core_hold    = (st_r != SMC_RUN);
  assign o_adc_start    = adc_start_r;
  assign o_bod_off      = bod_off_r;
  assign o_resume_irq   = res_irq_r;
  assign o_resume_reset = res_rst_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (i_paddr)
        `SMC_SLEEP_CTRL_OFS: o_prdata <= {28'h0000000, sm_r, se_r};
        `SMC_CPU_CTRL_OFS:   o_prdata <= {25'h0000000, brownout_sleep_off_active, unlock_r, 5'h00};
        `SMC_STATUS_OFS:     o_prdata <= {24'h000000, bod_off_r, mode_r, 2'h0, st_r};
        default:             o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_enter_needs_se;
    @(posedge i_clk) disable iff (!i_rstn)
      (st_r == SMC_RUN && st_nxt == SMC_SLEEP) |-> se_r && i_sleep_instr;
  endproperty
  a_enter_needs_se: assert property (p_enter_needs_se) else $error("sleep without enable");

  property p_reserved_no_sleep;
    @(posedge i_clk) disable iff (!i_rstn)
      (st_r == SMC_RUN && i_sleep_instr && (sm_r == 3'h4 || sm_r == 3'h5 || sm_r == 3'h7))
        |=> st_r == SMC_RUN;
  endproperty
  a_reserved_no_sleep: assert property (p_reserved_no_sleep) else $error("reserved mode slept");

  property p_idle_clocks;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleeping && mode_r == `SMC_MODE_IDLE) |-> !o_clk_en.cpu && o_clk_en.io && o_clk_en.adc;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock set wrong");

  property p_adcnr_clocks;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleeping && mode_r == `SMC_MODE_ADCNR) |-> !o_clk_en.io && o_clk_en.adc && o_clk_en.async;
  endproperty
  a_adcnr_clocks: assert property (p_adcnr_clocks) else $error("noise mode clock set wrong");

  property p_pdown_clocks;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleeping && mode_r == `SMC_MODE_PDOWN) |-> !o_clk_en.main_osc && !o_clk_en.adc && !o_clk_en.async;
  endproperty
  a_pdown_clocks: assert property (p_pdown_clocks) else $error("power-down clock on");

  property p_stby_wake;
    @(posedge i_clk) disable iff (!i_rstn)
      (st_r == SMC_SLEEP && mode_r == `SMC_MODE_STBY && !bod_off_r && !rst_q_r && wake_ok)
        |=> (st_r == SMC_WAKE) [*6] ##1 (st_r == SMC_RUN && o_resume_irq);
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake not six cycles");

  property p_idle_halt4;
    @(posedge i_clk) disable iff (!i_rstn)
      (st_r == SMC_SLEEP && mode_r == `SMC_MODE_IDLE && !rst_q_r && wake_ok)
        |=> o_core_hold [*4] ##1 (!o_core_hold && o_resume_irq);
  endproperty
  a_idle_halt4: assert property (p_idle_halt4) else $error("idle wake hold not four");

  property p_reset_vector;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleeping && rst_q_r) |=> o_resume_reset && st_r == SMC_RUN;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset did not resume");

  property p_bod_only_deep;
    @(posedge i_clk) disable iff (!i_rstn)
      o_bod_off |-> deep && st_r == SMC_SLEEP;
  endproperty
  a_bod_only_deep: assert property (p_bod_only_deep) else $error("brown-out off outside deep sleep");

  property p_brownout_sleep_off_window;
    @(posedge i_clk) disable iff (!i_rstn)
      (brownout_sleep_off_cnt_r == 3'h0 && brownout_sleep_off_cnt_nxt != 3'h0)
        |=> (!brownout_sleep_off_active) [*3] ##1 brownout_sleep_off_active [*3] ##1 !brownout_sleep_off_active;
  endproperty
  a_brownout_sleep_off_window: assert property (p_brownout_sleep_off_window) else $error("sleep-off window wrong");

  property p_brownout_sleep_off_locked;
    @(posedge i_clk) disable iff (!i_rstn)
      (wr_acc && i_paddr == `SMC_CPU_CTRL_OFS && !unlock_r) |=> $stable(brownout_sleep_off_cnt_r == 3'h0) || brownout_sleep_off_cnt_r != 3'h6;
  endproperty
  a_brownout_sleep_off_locked: assert property (p_brownout_sleep_off_locked) else $error("sleep-off set without unlock");

  property p_adc_start;
    @(posedge i_clk) disable iff (!i_rstn)
      (st_r == SMC_RUN && st_nxt == SMC_SLEEP && i_adc_enabled && sm_r == `SMC_MODE_ADCNR) |=> o_adc_start;
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("no adc start at entry");

  property p_ps_tosc;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleeping && mode_r == `SMC_MODE_PSAVE && !i_async_used) |-> !o_clk_en.tosc;
  endproperty
  a_ps_tosc: assert property (p_ps_tosc) else $error("timer oscillator left on");

  c_idle_wake:  cover property (@(posedge i_clk) disable iff (!i_rstn)
                  st_r == SMC_WAKE && mode_r == `SMC_MODE_IDLE ##[1:8] o_resume_irq);
  c_bod_sleep:  cover property (@(posedge i_clk) disable iff (!i_rstn) o_bod_off ##1 st_r == SMC_WAKE);
  c_reset_wake: cover property (@(posedge i_clk) disable iff (!i_rstn) o_resume_reset);

endmodule

// File: smc_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// core and wake-source stand-in
// ----------------------------------------
module smc_core_model
  import smc_pkg::*;
(
  input  wire logic      i_clk,         // system clock
  input  wire logic      i_rstn,        // async reset, active low
  input  wire logic      i_go,          // bench asks for a sleep instruction
  input  wire smc_wake_t i_src,         // wake sources raised by the bench
  input  wire logic      i_core_hold,   // core halted by the controller
  output logic           o_sleep_instr, // one-cycle sleep pulse
  output smc_wake_t      o_wake         // wake levels to the controller
);
  logic go_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      go_r          <= 1'b0;
      o_sleep_instr <= 1'b0;
      o_wake        <= '0;
    end else begin
      go_r          <= i_go;
      o_sleep_instr <= i_go & ~go_r;
      // a level source is kept up until the core runs again
      o_wake        <= i_src | (o_wake & {10{i_core_hold}});
    end
  end
endmodule

// File: sleep_mode_controller_tb.sv
`timescale 1ns/1ps
module sleep_mode_controller_tb;
  import smc_pkg::*;
  logic        i_clk, i_rstn, psel, penable, pwrite, pready, pslverr, err, rdy;
  logic        go, rst_ev, xtal, sleep_instr, core_hold, adc_start, bod_off, res_irq, res_rst;
  logic        adc_en, asyn_u, syn_u;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] refuse [5] = '{32'h0, 32'h9, 32'hb, 32'hf, 32'hd};
  smc_wake_t   src, wake;
  smc_clk_en_t clk_en;
  int          n_fail, n_compared, adc_cnt;

  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  smc_sleep_ctrl #(.SU_UNIT(1)) i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sleep_instr(sleep_instr), .i_reset_event(rst_ev), .i_wake(wake), .i_t2_irq_ovf_en(1'b1),
    .i_t2_irq_cmp_en(1'b0), .i_global_ie(1'b1), .i_xtal_sel(xtal), .i_clk_src_fuses(4'h1),
    .i_adc_enabled(adc_en), .i_async_used(asyn_u), .i_sync_used(syn_u), .o_clk_en(clk_en),
    .o_core_hold(core_hold), .o_adc_start(adc_start), .o_bod_off(bod_off),
    .o_resume_irq(res_irq), .o_resume_reset(res_rst));

  smc_core_model i_core (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_src(src), .i_core_hold(core_hold),
    .o_sleep_instr(sleep_instr), .o_wake(wake));

  always #12.5 i_clk = ~i_clk;

  always @(posedge i_clk) if (adc_start === 1'b1) adc_cnt++;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      rdy = pready;
      err = pslverr;
      rd  = prdata;
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) n_fail++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_sig(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (s !== 1'b1 && n < lim);
    chk("wait_cycles", 1, n >= 2 && n < lim);
  endtask

  // bad source first must not wake; hold counts from the good source
  task automatic nap(input logic wr, input logic [2:0] m, input logic [6:0] ce, input logic [9:0] s,
                     input logic [9:0] bad, input int hold, input logic brownout_detector);
    int n, a0;
    if (wr) apb(1'b1, 12'h000, {28'h0, m, 1'b1});
    a0 = adc_cnt;
    @(posedge i_clk);
    go  <= 1'b1;
    src <= bad;
    wait_sig(core_hold, 8);
    @(posedge i_clk);
    go <= 1'b0;
    #1 chk("clk_en", ce, clk_en);
    chk("bod_off", brownout_detector, bod_off);
    chk("adc_start", m < 3'h2, adc_cnt - a0);
    repeat (12) @(posedge i_clk);
    #1 chk("asleep", 1, core_hold);
    @(posedge i_clk);
    src <= s;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (res_irq !== 1'b1 && n < 3000);
    chk("wake_window", 1, n >= hold + 3 && n <= hold + 8);
    @(posedge i_clk);
    src <= '0;
    #1 chk("bod_on_wake", 0, bod_off);
    apb(1'b1, 12'h000, 32'h0);
    $display("test sleep mode %0d done", m);
  endtask

  task automatic arm();
    apb(1'b1, 12'h004, 32'h60);
    apb(1'b1, 12'h004, 32'h40);
    @(posedge i_clk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    test_done();
  end

  initial begin
    {i_clk, i_rstn, psel, penable, pwrite, go, rst_ev, xtal} = '0;
    {paddr, pwdata, src} = '0;
    {n_fail, n_compared, adc_cnt} = '0;
    {adc_en, asyn_u, syn_u} = 3'b110;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("cpu_ctrl_reset", 0, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    $display("test registers done");
    foreach (refuse[i]) begin
      apb(1'b1, 12'h000, refuse[i]);
      @(posedge i_clk);
      go <= 1'b1;
      repeat (8) @(posedge i_clk);
      go <= 1'b0;
      #1 chk("no_sleep", 0, core_hold);
    end
    $display("test refused sleep done");
    xtal <= 1'b1;
    nap(1'b1, 3'h0, 7'h1f, 10'h200, 10'h000, 4, 1'b0);
    nap(1'b1, 3'h1, 7'h0f, 10'h100, 10'h200, 4, 1'b0);
    nap(1'b1, 3'h2, 7'h00, 10'h001, 10'h100, 6, 1'b0);
    nap(1'b1, 3'h3, 7'h05, 10'h020, 10'h010, 6, 1'b0);
    nap(1'b1, 3'h6, 7'h02, 10'h002, 10'h080, 6, 1'b0);
    apb(1'b1, 12'h000, 32'h5);
    arm();
    nap(1'b0, 3'h2, 7'h00, 10'h001, 10'h000, 2400, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    arm();
    nap(1'b0, 3'h0, 7'h1f, 10'h200, 10'h000, 4, 1'b0);
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b1, 12'h004, 32'h40);
    @(posedge i_clk);
    nap(1'b0, 3'h2, 7'h00, 10'h001, 10'h000, 6, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    @(posedge i_clk);
    go <= 1'b1;
    wait_sig(core_hold, 8);
    @(posedge i_clk);
    go     <= 1'b0;
    rst_ev <= 1'b1;
    wait_sig(res_rst, 12);
    chk("resume_reset", 1, res_rst);
    chk("run_after_reset", 0, core_hold);
    @(posedge i_clk);
    rst_ev <= 1'b0;
    $display("test reset wake done");
    test_done();
  end
endmodule
